// file: pkg/abc_map.svh
/*
 * Register map, field positions, reset values and codes of the per-area
 * bus control register bank.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef ABC_MAP_SVH
`define ABC_MAP_SVH

// Byte address of an area register is the area number times the stride.
`define ABC_AREA_STRIDE    8'h04
`define ABC_ADDR_W         8
`define ABC_AREA_W         3

// Field positions inside the 32-bit register word.
`define ABC_IDLE_OTHER_HI  20
`define ABC_IDLE_OTHER_LO  19
`define ABC_IDLE_SAME_HI   17
`define ABC_IDLE_SAME_LO   16
`define ABC_KIND_HI        15
`define ABC_KIND_LO        12
`define ABC_WIDTH_HI       10
`define ABC_WIDTH_LO       9

// Writable bits and the reset image; everything else reads as zero.
`define ABC_WR_MASK        32'h001BF600
`define ABC_RESET_VAL      32'h001B0600
`define ABC_A0_WIDTH_RST   2'h3

// Memory kind codes.
`define ABC_KIND_NORMAL    4'h0
`define ABC_KIND_BYTESRAM  4'h3
`define ABC_KIND_SDRAM     4'h4
`define ABC_KIND_PCMCIA    4'h5

// Bus width codes.
`define ABC_WIDTH_8        2'h1
`define ABC_WIDTH_16       2'h2

// Idle cycle counts for the four idle codes.
`define ABC_IDLE_C0        3'h0
`define ABC_IDLE_C1        3'h1
`define ABC_IDLE_C2        3'h2
`define ABC_IDLE_C3        3'h4
`define ABC_GAP_MAX        3'h7

`endif

// file: pkg/abc_pkg.sv
/*
 * Types shared by the bus control register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package abc_pkg;
    typedef logic [2:0]  abc_area_t;
    typedef logic [31:0] abc_word_t;
    typedef logic [3:0]  abc_kind_t;
    typedef logic [1:0]  abc_width_t;
    typedef logic [2:0]  abc_count_t;
endpackage

`default_nettype wire

// file: pkg/abc_cfg_if.sv
/*
 * Carrier between the control logic and the register storage.
 * Assumes one clock; read data come back one cycle after the address.
 */
`default_nettype none

interface abc_cfg_if;
    logic               wr_en;
    abc_pkg::abc_area_t wr_area;
    abc_pkg::abc_word_t wr_data;
    abc_pkg::abc_area_t rd_area_a;
    abc_pkg::abc_word_t rd_data_a;
    abc_pkg::abc_area_t rd_area_b;
    abc_pkg::abc_word_t rd_data_b;

    modport ctl (output wr_en, wr_area, wr_data, rd_area_a, rd_area_b,
                 input rd_data_a, rd_data_b);
    modport mem (input wr_en, wr_area, wr_data, rd_area_a, rd_area_b,
                 output rd_data_a, rd_data_b);
endinterface

`default_nettype wire

// file: hw/abc_mem.sv
/*
 * Storage of the eight area register words with one write port and two
 * registered read ports.
 * Assumes a synchronised active-low reset and write data already masked.
 */
`default_nettype none
`include "abc_map.svh"

module abc_mem (
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    abc_cfg_if.mem      cfg
);
    abc_pkg::abc_word_t word_r [8];
    abc_pkg::abc_word_t rda_r;
    abc_pkg::abc_word_t rdb_r;
    abc_pkg::abc_word_t rda_nxt;
    abc_pkg::abc_word_t rdb_nxt;

    // One storage word per area; unused areas are never written but can still be read.
    for (genvar i = 0; i < 8; i++) begin : g_word
        abc_pkg::abc_word_t word_nxt;
        always_comb begin
            word_nxt = word_r[i];
            if (ce && cfg.wr_en && cfg.wr_area == abc_pkg::abc_area_t'(i)) begin
                word_nxt = cfg.wr_data;
            end
        end
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                word_r[i] <= `ABC_RESET_VAL;
            end else begin
                word_r[i] <= word_nxt;
            end
        end
    end

    // Read ports are registered so the data leave from flip-flops.
    always_comb begin
        rda_nxt = ce ? word_r[cfg.rd_area_a] : rda_r;
        rdb_nxt = ce ? word_r[cfg.rd_area_b] : rdb_r;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rda_r <= 32'h00000000;
            rdb_r <= `ABC_RESET_VAL;
        end else begin
            rda_r <= rda_nxt;
            rdb_r <= rdb_nxt;
        end
    end

    assign cfg.rd_data_a = rda_r;
    assign cfg.rd_data_b = rdb_r;
endmodule

`default_nettype wire

// file: hw/abc_top.sv
/*
 * Per-area bus control register bank: idle cycle fields, memory kind and
 * bus width for areas 0, 3, 4, 5 and 6, with read-to-read idle insertion
 * on a simple access port.
 * Assumes inputs synchronous to core_clk and a register master that never
 * waits.
 */
`default_nettype none
`include "abc_map.svh"

module abc_top (
    input  wire logic                core_clk,
    input  wire logic                nrst,
    input  wire logic                ce,
    input  wire logic                width_mode_pin,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    input  wire logic                acc_valid,
    input  wire logic [2:0]          acc_area,
    input  wire logic                acc_read,
    output logic                     acc_ready,
    output logic      [1:0]          acc_width,
    output logic      [3:0]          acc_kind,
    output logic                     acc_cfg_bad
);
    abc_cfg_if cfg ();

    logic [1:0]             rst_sync_r;
    logic                   rst_n;
    logic                   strap_done_r;
    logic                   strap_done_nxt;
    abc_pkg::abc_width_t    a0_width_r;
    abc_pkg::abc_width_t    a0_width_nxt;
    abc_pkg::abc_area_t     last_area_r;
    abc_pkg::abc_area_t     last_area_nxt;
    logic                   last_read_r;
    logic                   last_read_nxt;
    logic                   have_last_r;
    logic                   have_last_nxt;
    abc_pkg::abc_count_t    gap_r;
    abc_pkg::abc_count_t    gap_nxt;
    logic                   rd_vld_r;
    logic                   rd_vld_nxt;
    logic                   rd_a0_r;
    logic                   rd_a0_nxt;
    logic                   take;
    abc_pkg::abc_count_t    need;
    abc_pkg::abc_word_t     cfgb;

    // True for an address that lands on a register of an existing area.
    function automatic logic is_mapped(input logic [7:0] addr);
        logic [2:0] area;
        area = addr[4:2];
        is_mapped = (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0) &&
                    (area == 3'h0 || area == 3'h3 || area == 3'h4 ||
                     area == 3'h5 || area == 3'h6);
    endfunction

    // Idle cycles for a two-bit idle code.
    function automatic abc_pkg::abc_count_t idle_cycles(input logic [1:0] code);
        case (code)
            2'h0:    idle_cycles = `ABC_IDLE_C0;
            2'h1:    idle_cycles = `ABC_IDLE_C1;
            2'h2:    idle_cycles = `ABC_IDLE_C2;
            default: idle_cycles = `ABC_IDLE_C3;
        endcase
    endfunction

    // Flags a setting that software should never have made.
    function automatic logic cfg_bad(input abc_pkg::abc_area_t area,
                                     input abc_pkg::abc_kind_t kind,
                                     input abc_pkg::abc_width_t wid);
        logic kind_bad;
        logic wid_bad;
        kind_bad = !(kind == `ABC_KIND_NORMAL || kind == `ABC_KIND_BYTESRAM ||
                     kind == `ABC_KIND_SDRAM || kind == `ABC_KIND_PCMCIA);
        // Both legal widths are accepted for PCMCIA on areas 5 and 6 too.
        wid_bad = !(wid == `ABC_WIDTH_8 || wid == `ABC_WIDTH_16);
        if (area == 3'h3 && kind == `ABC_KIND_SDRAM && wid != `ABC_WIDTH_16) begin
            wid_bad = 1'b1;
        end
        cfg_bad = kind_bad || wid_bad;
    endfunction

    // Reset release goes through two flip-flops; assertion stays asynchronous.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    abc_mem u_mem (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .cfg      (cfg.ctl)
    );

    // Software writes keep only the writable bits, so reserved bits stay zero.
    assign cfg.wr_en     = reg_wr && is_mapped(reg_addr);
    assign cfg.wr_area   = reg_addr[4:2];
    assign cfg.wr_data   = reg_wdata & `ABC_WR_MASK;
    assign cfg.rd_area_a = reg_addr[4:2];
    // Port b follows the area being taken, then holds on the last one.
    assign cfg.rd_area_b = take ? acc_area : last_area_r;
    assign cfgb          = cfg.rd_data_b;

    // Idle count taken from the register of the area accessed first.
    always_comb begin
        if (last_area_r == acc_area) begin
            need = idle_cycles(cfgb[`ABC_IDLE_SAME_HI:`ABC_IDLE_SAME_LO]);
        end else begin
            need = idle_cycles(cfgb[`ABC_IDLE_OTHER_HI:`ABC_IDLE_OTHER_LO]);
        end
    end

    // A read right after a read waits until enough idle cycles have gone by.
    assign acc_ready = ce && (!have_last_r || !(acc_read && last_read_r) ||
                              gap_r >= need);
    assign take      = acc_valid && acc_ready;

    // Configuration of the last taken area; area 0 width is the strap copy.
    assign acc_kind    = cfgb[`ABC_KIND_HI:`ABC_KIND_LO];
    assign acc_width   = (last_area_r == 3'h0) ? a0_width_r
                                               : cfgb[`ABC_WIDTH_HI:`ABC_WIDTH_LO];
    assign acc_cfg_bad = have_last_r && cfg_bad(last_area_r, acc_kind, acc_width);

    // Read data only in the cycle after the strobe; area 0 shows the strap.
    always_comb begin
        reg_rdata = 32'h00000000;
        if (rd_vld_r) begin
            reg_rdata = cfg.rd_data_a;
            if (rd_a0_r) begin
                reg_rdata[`ABC_WIDTH_HI:`ABC_WIDTH_LO] = a0_width_r;
            end
        end
    end

    // Next values of the control state; low ce freezes everything.
    always_comb begin
        strap_done_nxt = strap_done_r;
        a0_width_nxt   = a0_width_r;
        last_area_nxt  = last_area_r;
        last_read_nxt  = last_read_r;
        have_last_nxt  = have_last_r;
        gap_nxt        = gap_r;
        rd_vld_nxt     = rd_vld_r;
        rd_a0_nxt      = rd_a0_r;
        if (ce) begin
            // Strap captured once, on the first enabled cycle after release.
            if (!strap_done_r) begin
                strap_done_nxt = 1'b1;
                a0_width_nxt   = width_mode_pin ? `ABC_WIDTH_16 : `ABC_WIDTH_8;
            end
            rd_vld_nxt = reg_rd && is_mapped(reg_addr);
            rd_a0_nxt  = reg_addr[4:2] == 3'h0;
            if (take) begin
                last_area_nxt = acc_area;
                last_read_nxt = acc_read;
                have_last_nxt = 1'b1;
                gap_nxt       = 3'h0;
            end else if (gap_r != `ABC_GAP_MAX) begin
                gap_nxt = gap_r + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_r <= 1'b0;
            a0_width_r   <= `ABC_A0_WIDTH_RST;
            last_area_r  <= 3'h0;
            last_read_r  <= 1'b0;
            have_last_r  <= 1'b0;
            gap_r        <= 3'h0;
            rd_vld_r     <= 1'b0;
            rd_a0_r      <= 1'b0;
        end else begin
            strap_done_r <= strap_done_nxt;
            a0_width_r   <= a0_width_nxt;
            last_area_r  <= last_area_nxt;
            last_read_r  <= last_read_nxt;
            have_last_r  <= have_last_nxt;
            gap_r        <= gap_nxt;
            rd_vld_r     <= rd_vld_nxt;
            rd_a0_r      <= rd_a0_nxt;
        end
    end

    // Checks of the documented behaviour.
    chk_other_idle_four: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (acc_valid && acc_read && have_last_r && last_read_r &&
         last_area_r != acc_area && cfgb[20:19] == 2'h3 && gap_r < 3'h4)
        |-> !acc_ready)
        else $error("Read to other area taken before four idle cycles.");

    chk_same_idle_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ce && acc_valid && acc_read && have_last_r && last_read_r &&
         last_area_r == acc_area && cfgb[17:16] == 2'h0) |-> acc_ready)
        else $error("Same-area read stalled although no idle cycle is set.");

    chk_reserved_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ce && reg_rd) |=> ((reg_rdata & 32'hFFE409FF) == 32'h00000000))
        else $error("Reserved bit read back as one.");

    chk_kind_prohibit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (have_last_r && (acc_kind == 4'h1 || acc_kind == 4'h2 || acc_kind > 4'h5))
        |-> acc_cfg_bad)
        else $error("Prohibited memory kind not flagged.");

    chk_width_prohibit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (have_last_r && (acc_width == 2'h0 || acc_width == 2'h3)) |-> acc_cfg_bad)
        else $error("Prohibited bus width not flagged.");

    chk_area0_width_kept: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (strap_done_r && reg_wr && reg_addr == 8'h00) |=> $stable(a0_width_r))
        else $error("Software write changed the area 0 bus width.");

    chk_pcmcia_width: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (have_last_r && (last_area_r == 3'h5 || last_area_r == 3'h6) &&
         acc_kind == 4'h5 && (acc_width == 2'h1 || acc_width == 2'h2))
        |-> !acc_cfg_bad)
        else $error("Legal PCMCIA width flagged as bad.");

    chk_strap_load: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(strap_done_r) |->
        a0_width_r == ($past(width_mode_pin) ? 2'h2 : 2'h1))
        else $error("Area 0 width does not match the mode pin.");

    chk_first_area_used: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ce && take) |=> (last_area_r == $past(acc_area) && gap_r == 3'h0))
        else $error("Taken access not recorded as the first area.");
endmodule

`default_nettype wire

// file: testbench/abc_ext_mem.sv
/*
 * Behavioural model of the requester on the access port.
 * Assumes one clock; requests are queued by the bench through push().
 */
`default_nettype none

module abc_ext_mem (
    input  wire logic       core_clk,
    input  wire logic       acc_ready,
    output logic            acc_valid,
    output logic [2:0]      acc_area,
    output logic            acc_read
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] req_q[$];
    int         stall_q[$];
    int         stall_n = 0;

    initial begin
        acc_valid = 1'b0;
        acc_area  = 3'h0;
        acc_read  = 1'b0;
    end

    // Queue one access; the model presents it at the next free edge.
    task automatic push(input logic [2:0] area, input logic rd);
        req_q.push_back({rd, area});
    endtask

    // A request is held until taken, and the stall is logged per request.
    // Idle lines toggle so a stale area is never mistaken for a request.
    always @(posedge core_clk) begin
        if (acc_valid && acc_ready) begin
            stall_q.push_back(stall_n);
        end
        if (!acc_valid || acc_ready) begin
            if (req_q.size() > 0) begin
                {acc_read, acc_area} <= req_q.pop_front();
                acc_valid <= 1'b1;
                stall_n <= 0;
            end else begin
                acc_valid <= 1'b0;
                acc_area <= ~acc_area;
                acc_read <= ~acc_read;
            end
        end else begin
            stall_n <= stall_n + 1;
        end
    end
endmodule

`default_nettype wire

// file: testbench/tb_area_bus_control_fields.sv
/*
 * Self-checking bench of the area bus control register bank.
 * Assumes the abc_top ports and the requester model abc_ext_mem.
 */
`default_nettype none

module tb_area_bus_control_fields;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, nrst, ce, width_mode_pin, reg_wr, reg_rd;
    logic acc_valid, acc_read, acc_ready, acc_cfg_bad;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0]  acc_area;
    logic [1:0]  acc_width;
    logic [3:0]  acc_kind;
    int bad_count = 0;
    int cmp_count = 0;
    int idle_cyc[4] = '{0, 1, 2, 4};
    // Entries: area, kind, width, expected bad flag.
    logic [9:0] cfg_tbl[9] = '{{3'd5, 4'h5, 2'h1, 1'b0}, {3'd6, 4'h5, 2'h2, 1'b0},
        {3'd3, 4'h4, 2'h1, 1'b1}, {3'd3, 4'h4, 2'h2, 1'b0}, {3'd4, 4'h3, 2'h2, 1'b0},
        {3'd4, 4'h0, 2'h1, 1'b0}, {3'd4, 4'h1, 2'h1, 1'b1}, {3'd5, 4'h0, 2'h0, 1'b1},
        {3'd6, 4'h0, 2'h3, 1'b1}};

    abc_top i_abc_top (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .width_mode_pin(width_mode_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_valid(acc_valid),
        .acc_area(acc_area), .acc_read(acc_read), .acc_ready(acc_ready),
        .acc_width(acc_width), .acc_kind(acc_kind), .acc_cfg_bad(acc_cfg_bad));

    abc_ext_mem i_abc_ext_mem (.core_clk(core_clk), .acc_ready(acc_ready),
        .acc_valid(acc_valid), .acc_area(acc_area), .acc_read(acc_read));

    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic wait_taken(input int n);
        for (int i = 0; i < 60 && i_abc_ext_mem.stall_q.size() < n; i++) begin
            @(posedge core_clk);
            #1;
        end
        // A limit that runs out shows up here as a short count.
        chk(32'(i_abc_ext_mem.stall_q.size()), 32'(n));
    endtask

    task automatic do_reset(input logic pin);
        nrst <= 1'b0;
        width_mode_pin <= pin;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic t_reset_image;
        int al[4] = '{3, 4, 5, 6};
        rd(8'h00, 32'h001B0400);
        foreach (al[i]) rd({3'h0, 3'(al[i]), 2'h0}, 32'h001B0600);
        do_reset(1'b0);
        rd(8'h00, 32'h001B0200);
        do_reset(1'b1);
    endtask

    task automatic t_reserved;
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h001BF600);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h00000000);
    endtask

    task automatic t_area0;
        int base;
        base = i_abc_ext_mem.stall_q.size();
        wr(8'h00, 32'h00000200);
        rd(8'h00, 32'h00000400);
        i_abc_ext_mem.push(3'd0, 1'b0);
        wait_taken(base + 1);
        chk({29'h0, acc_width, acc_cfg_bad}, {29'h0, 2'h2, 1'b0});
    endtask

    // Writes never wait for idle cycles, so every entry is taken without idle cycles.
    task automatic t_kinds;
        logic [9:0] e;
        int base;
        foreach (cfg_tbl[i]) begin
            e = cfg_tbl[i];
            base = i_abc_ext_mem.stall_q.size();
            wr({3'h0, e[9:7], 2'h0}, {16'h0, e[6:3], 1'b0, e[2:1], 9'h0});
            i_abc_ext_mem.push(e[9:7], 1'b0);
            wait_taken(base + 1);
            chk({25'h0, acc_kind, acc_width, acc_cfg_bad}, {25'h0, e[6:0]});
        end
    endtask

    // Each pair of reads is judged by the stall of its second read only.
    task automatic pair(input logic [2:0] a1, input logic [2:0] a2, input int exp);
        int base;
        base = i_abc_ext_mem.stall_q.size();
        i_abc_ext_mem.push(a1, 1'b1);
        i_abc_ext_mem.push(a2, 1'b1);
        wait_taken(base + 2);
        chk(32'(i_abc_ext_mem.stall_q[base + 1]), 32'(exp));
    endtask

    task automatic t_idle;
        for (int c = 0; c < 4; c++) begin
            wr(8'h0C, {11'h0, 2'(c), 1'b0, 2'(3 - c), 4'h0, 1'b0, 2'h2, 9'h0});
            wr(8'h10, 32'h00000200);
            pair(3'd3, 3'd3, idle_cyc[3 - c]);
            pair(3'd3, 3'd4, idle_cyc[c]);
            pair(3'd4, 3'd3, 0);
        end
    endtask

    // Low ce freezes the bank, so a pending access must wait until it returns.
    task automatic t_freeze;
        int base;
        base = i_abc_ext_mem.stall_q.size();
        ce <= 1'b0;
        i_abc_ext_mem.push(3'd5, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        chk(32'(i_abc_ext_mem.stall_q.size()), 32'(base));
        ce <= 1'b1;
        wait_taken(base + 1);
        chk({25'h0, acc_kind, acc_width, acc_cfg_bad}, {25'h0, 4'h0, 2'h0, 1'b1});
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence; inputs start defined and reset is held 8 cycles.
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        width_mode_pin = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        do_reset(1'b1);
        t_reset_image;
        t_reserved;
        t_area0;
        t_kinds;
        t_idle;
        t_freeze;
        summarize;
    end

    // The whole run needs well under 2000 cycles; this cuts a hang short.
    initial begin
        #200000;
        bad_count++;
        summarize;
    end
endmodule

`default_nettype wire
